/* File: hdl/laser_power_and_test_regs.v */
// Laser drive configuration, observation and pixel grab registers
// Assumes a serial master on the four-wire port; SPI mode 3, MSB first
// Assumes frame strobe, power state and pixel data from the sensor core
`timescale 1ns/1ps
`include "laser_test_regs_defines.vh"
module laser_power_and_test_regs
#(
   parameter PIX_COLS = 30,
   parameter PIX_ROWS = 30,
   parameter PIX_AW = 10,
   parameter COLUMN_MAJOR = 1
)
(
   input wire clk_sys_in,
   input wire sys_rst_in,
   input wire ncs_in,
   input wire sclk_in,
   input wire mosi_in,
   output reg miso_out,
   output reg miso_oe_out,
   input wire frame_tick_in,
   input wire [1:0] power_state_in,
   input wire [7:0] pixel_data_in,
   output reg [PIX_AW-1:0] pixel_addr_out,
   output reg [7:0] laser_dac_code_out,
   output reg [1:0] laser_range_out,
   output reg laser_on_active_low_out,
   output reg laser_setting_valid_out
);
   // ****************************************************
   // Pin synchronisers
   // ****************************************************
   wire ncs_s;
   wire sclk_s;
   wire mosi_s;
   sync_two_ff u_sync_ncs (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .async_in(ncs_in), .rst_val_in(1'b1),
      .sync_out(ncs_s));
   sync_two_ff u_sync_sclk (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .async_in(sclk_in), .rst_val_in(1'b1),
      .sync_out(sclk_s));
   sync_two_ff u_sync_mosi (.clk_sys_in(clk_sys_in),
      .sys_rst_in(sys_rst_in), .async_in(mosi_in), .rst_val_in(1'b0),
      .sync_out(mosi_s));

   // ****************************************************
   // Registers
   // ****************************************************
   reg [7:0] laser_control_zero;
   reg [7:0] laser_current_code;
   reg [7:0] laser_current_complement;
   reg [7:0] laser_range_complement;
   reg [4:0] frame_activity_bits;
   reg [7:0] pixel_readout_port;
   reg pixel_data_ready;
   reg first_pixel_flag;
   reg [PIX_AW-1:0] pix_index;
   reg pix_wrapped;

   wire current_pair_ok;
   wire range_pair_ok;
   wire range_usable;
   wire setting_ok;
   assign current_pair_ok =
      (laser_current_code == ~laser_current_complement); // [R1] [R2]
   assign range_pair_ok =
      (laser_control_zero[7:6] == ~laser_range_complement[7:6]); // [R4] [R5]
   assign range_usable =
      (laser_control_zero[7:6] != `RANGE_INVALID); // [R16]
   assign setting_ok = current_pair_ok & range_pair_ok & range_usable; // [R17]

   // ****************************************************
   // Serial frame engine
   // ****************************************************
   localparam ST_ADDR = 3'b001;
   localparam ST_WDATA = 3'b010;
   localparam ST_RDATA = 3'b100;
   reg [2:0] state;
   reg [2:0] bit_cnt;
   reg [7:0] shift_in;
   reg [7:0] shift_out;
   reg [6:0] addr;
   reg sclk_d;
   wire sclk_rise;
   wire sclk_fall;
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   wire [7:0] next_shift_in;
   assign next_shift_in = {shift_in[6:0], mosi_s};

   reg wr_stb;
   reg rd_stb;
   reg [7:0] wr_data;
   reg [6:0] wr_addr;
   reg [7:0] rd_word;

   always @*
   begin
      case (next_shift_in[6:0])
         `ADDR_LASER_CONTROL_ZERO: rd_word = laser_control_zero;
         `ADDR_CURRENT_CODE: rd_word = laser_current_code;
         `ADDR_CURRENT_COMPLEMENT: rd_word = laser_current_complement;
         `ADDR_RANGE_COMPLEMENT: rd_word = laser_range_complement;
         `ADDR_FRAME_ACTIVITY:
            rd_word = {power_state_in, 1'b0, frame_activity_bits}; // [R9]
         `ADDR_PIXEL_READOUT: rd_word = pixel_readout_port;
         `ADDR_MOTION_STATUS:
            rd_word = {2'b00, laser_setting_valid_out, 3'b000,
               first_pixel_flag, pixel_data_ready}; // [R12]
         default: rd_word = `RESET_BYTE;
      endcase
   end

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         state <= ST_ADDR;
         bit_cnt <= 3'h0;
         shift_in <= 8'h00;
         shift_out <= 8'h00;
         addr <= 7'h00;
         sclk_d <= 1'b1;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         wr_data <= 8'h00;
         wr_addr <= 7'h00;
         miso_out <= 1'b0;
         miso_oe_out <= 1'b0;
      end
      else
      begin
         sclk_d <= sclk_s;
         wr_stb <= 1'b0;
         rd_stb <= 1'b0;
         miso_oe_out <= (state == ST_RDATA) & ~ncs_s;
         if (ncs_s)
         begin
            state <= ST_ADDR;
            bit_cnt <= 3'h0;
         end
         else
         begin
            if (sclk_fall && state == ST_RDATA)
            begin
               miso_out <= shift_out[7];
               shift_out <= {shift_out[6:0], 1'b0};
            end
            if (sclk_rise)
            begin
               shift_in <= next_shift_in;
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7)
               begin
                  case (state)
                     ST_ADDR:
                     begin
                        addr <= next_shift_in[6:0];
                        if (next_shift_in[`SPI_WRITE_BIT])
                           state <= ST_WDATA;
                        else
                        begin
                           state <= ST_RDATA;
                           shift_out <= rd_word;
                           rd_stb <= 1'b1;
                           wr_addr <= next_shift_in[6:0];
                        end
                     end
                     ST_WDATA:
                     begin
                        wr_stb <= 1'b1;
                        wr_data <= next_shift_in;
                        wr_addr <= addr;
                        state <= ST_ADDR;
                     end
                     ST_RDATA: state <= ST_ADDR;
                     default: state <= ST_ADDR;
                  endcase
               end
            end
         end
      end
   end

   // ****************************************************
   // Register file and pixel grab
   // ****************************************************
   wire wr_obs;
   wire wr_pix;
   wire rd_pix;
   wire last_pix;
   assign wr_obs = wr_stb & (wr_addr == `ADDR_FRAME_ACTIVITY);
   assign wr_pix = wr_stb & (wr_addr == `ADDR_PIXEL_READOUT);
   assign rd_pix = rd_stb & (wr_addr == `ADDR_PIXEL_READOUT);
   assign last_pix = (pix_index == PIX_COLS * PIX_ROWS - 1);

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         laser_control_zero <= `RESET_BYTE;
         laser_current_code <= `RESET_BYTE;
         laser_current_complement <= `RESET_BYTE;
         laser_range_complement <= `RESET_BYTE;
         frame_activity_bits <= 5'h00;
         pixel_readout_port <= `RESET_BYTE;
         pixel_data_ready <= 1'b0;
         first_pixel_flag <= 1'b0;
         pix_index <= {PIX_AW{1'b0}};
         pix_wrapped <= 1'b1;
      end
      else
      begin
         if (wr_stb)
         begin
            case (wr_addr)
               `ADDR_LASER_CONTROL_ZERO: laser_control_zero <= wr_data;
               `ADDR_CURRENT_CODE: laser_current_code <= wr_data; // [R2]
               `ADDR_CURRENT_COMPLEMENT:
                  laser_current_complement <= wr_data; // [R2]
               `ADDR_RANGE_COMPLEMENT:
                  laser_range_complement <= wr_data; // [R5]
               default: ;
            endcase
         end
         // Frame set wins over a clearing write
         if (frame_tick_in)
            frame_activity_bits <= `ACTIVITY_MASK; // [R6]
         else if (wr_obs)
            frame_activity_bits <= 5'h00; // [R7]
         if (wr_pix)
         begin
            pix_index <= {PIX_AW{1'b0}}; // [R11]
            pix_wrapped <= 1'b1;
            pixel_data_ready <= 1'b0;
         end
         else if (rd_pix)
         begin
            pixel_data_ready <= 1'b0;
            pix_wrapped <= last_pix; // [R14]
            if (last_pix)
               pix_index <= {PIX_AW{1'b0}}; // [R14]
            else
               pix_index <= pix_index + {{(PIX_AW-1){1'b0}}, 1'b1}; // [R13]
         end
         else if (frame_tick_in && !pixel_data_ready)
         begin
            pixel_readout_port <= pixel_data_in; // [R10]
            pixel_data_ready <= 1'b1; // [R12]
            first_pixel_flag <= pix_wrapped; // [R14]
         end
      end
   end

   // ****************************************************
   // Laser drive outputs
   // ****************************************************
   integer col_i;
   integer row_i;
   always @*
   begin
      col_i = 0;
      row_i = 0;
      if (COLUMN_MAJOR != 0)
      begin
         col_i = pix_index / PIX_ROWS;
         row_i = pix_index % PIX_ROWS;
      end
      else
      begin
         row_i = pix_index / PIX_COLS;
         col_i = pix_index % PIX_COLS;
      end
   end

   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         laser_dac_code_out <= 8'h00;
         laser_range_out <= 2'h0;
         laser_on_active_low_out <= 1'b1;
         laser_setting_valid_out <= 1'b0;
         pixel_addr_out <= {PIX_AW{1'b0}};
      end
      else
      begin
         laser_dac_code_out <= laser_current_code; // [R3]
         laser_range_out <= laser_control_zero[7:6];
         laser_setting_valid_out <= current_pair_ok & range_pair_ok; // [R17]
         laser_on_active_low_out <=
            laser_control_zero[`FORCE_OFF_BIT] | ~setting_ok; // [R15] [R1]
         pixel_addr_out <= row_i[PIX_AW-1:0] * PIX_COLS[PIX_AW-1:0]
            + col_i[PIX_AW-1:0]; // [R18]
      end
   end
endmodule

/* File: hdl/laser_test_regs_defines.vh */
// Offsets, fields, reset values and counts of the laser and test registers
// Assumes inclusion by bare name from design files under hdl/
// Behaviour
// [R1] - Current code and complement must be complementary
// [R2] - Current pair writable in any order
// [R3] - Current code drives 8-bit DAC
// [R4] - Range complement bits invert control range bits
// [R5] - Range pair writable in any order
// [R6] - Each frame sets five activity bits
// [R7] - Any observation write clears activity bits; the code sets them instead when a frame tick lands in the same cycle
// [R8] - Controller waits one frame before readback
// [R9] - Bits 7:6 report power state
// [R10] - Pixel grab returns one pixel per frame
// [R11] - Grab write resets pointer to pixel zero
// [R12] - Pixel ready flag set when data valid
// [R13] - Grab read advances pixel pointer
// [R14] - Full frame read sets first flag, wraps
// [R15] - Force-off bit holds laser enable high
// [R16] - Range pattern 10 is invalid, laser off
// [R17] - Valid flag needs both pairs; gates laser
// [R18] - Array size and scan order are parameters
`ifndef LASER_TEST_REGS_DEFINES_VH
`define LASER_TEST_REGS_DEFINES_VH
`define ADDR_LASER_CONTROL_ZERO 7'h1A
`define ADDR_CURRENT_CODE 7'h1C
`define ADDR_CURRENT_COMPLEMENT 7'h1D
`define ADDR_RANGE_COMPLEMENT 7'h1F
`define ADDR_FRAME_ACTIVITY 7'h2E
`define ADDR_PIXEL_READOUT 7'h35
`define ADDR_MOTION_STATUS 7'h02
`define RESET_BYTE 8'h00
`define FORCE_OFF_BIT 0
`define RANGE_HI_BIT 7
`define RANGE_LO_BIT 6
`define RANGE_INVALID 2'h2
`define VALID_BIT 5
`define PIXEL_DATA_READY_BIT 0
`define FIRST_BIT 1
`define ACTIVITY_MASK 5'h1F
`define SPI_WRITE_BIT 7
`endif

/* File: hdl/sync_two_ff.v */
// Two flip-flop synchroniser for one level
// Assumes a single clock domain on clk_sys_in
`timescale 1ns/1ps
module sync_two_ff
(
   input wire clk_sys_in,
   input wire sys_rst_in,
   input wire async_in,
   input wire rst_val_in,
   output reg sync_out
);
   reg stage_one;
   always @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         stage_one <= rst_val_in;
         sync_out <= rst_val_in;
      end
      else
      begin
         stage_one <= async_in;
         sync_out <= stage_one;
      end
   end
endmodule

/* File: sim/laser_power_and_test_regs_assertions.sv */
// Port checker for the laser and test register block
// Assumes it is bound to the block's top module
`timescale 1ns/1ps
module laser_regs_checker
#(
   parameter PIX_COLS = 30,
   parameter PIX_ROWS = 30,
   parameter PIX_AW = 10,
   parameter COLUMN_MAJOR = 1
)
(
   input wire clk_sys_in,
   input wire sys_rst_in,
   input wire ncs_in,
   input wire miso_oe_out,
   input wire [PIX_AW-1:0] pixel_addr_out,
   input wire [7:0] laser_dac_code_out,
   input wire [1:0] laser_range_out,
   input wire laser_on_active_low_out,
   input wire laser_setting_valid_out
);
   // **********
   // Properties
   // **********
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);
   // Next address in scan order; column-major walks a column first
   function automatic int next_addr(input int a);
      if (COLUMN_MAJOR != 0 && a / PIX_COLS == PIX_ROWS - 1)
         return a % PIX_COLS + 1;
      if (COLUMN_MAJOR != 0)
         return a + PIX_COLS;
      return a + 1;
   endfunction
   property p_on_needs_valid;
      !laser_on_active_low_out |->
         laser_setting_valid_out || $past(laser_setting_valid_out);
   endproperty
   a_on_needs_valid: assert property (p_on_needs_valid)
      else $error("laser on without valid flag");
   property p_bad_range_off;
      laser_range_out == 2'h2 && $past(laser_range_out) == 2'h2 |->
         laser_on_active_low_out;
   endproperty
   a_bad_range_off: assert property (p_bad_range_off)
      else $error("laser on with invalid range");
   property p_reset_off;
      $past(sys_rst_in) |->
         laser_on_active_low_out && !laser_setting_valid_out;
   endproperty
   a_reset_off: assert property (p_reset_off)
      else $error("laser not off after reset");
   property p_invalid_off;
      !laser_setting_valid_out [*2] |-> laser_on_active_low_out;
   endproperty
   a_invalid_off: assert property (p_invalid_off)
      else $error("laser on while setting invalid");
   property p_addr_range;
      pixel_addr_out < PIX_COLS * PIX_ROWS;
   endproperty
   a_addr_range: assert property (p_addr_range)
      else $error("pixel pointer past last pixel");
   property p_addr_step;
      pixel_addr_out != $past(pixel_addr_out) |-> pixel_addr_out == 0
         || pixel_addr_out == next_addr($past(pixel_addr_out));
   endproperty
   a_addr_step: assert property (p_addr_step)
      else $error("pixel pointer jumped");
   property p_addr_idle;
      ncs_in [*8] |=> $stable(pixel_addr_out);
   endproperty
   a_addr_idle: assert property (p_addr_idle)
      else $error("pixel pointer moved without access");
   property p_drive_idle;
      ncs_in [*8] |=> $stable({laser_dac_code_out, laser_range_out});
   endproperty
   a_drive_idle: assert property (p_drive_idle)
      else $error("laser drive moved without access");
   property p_oe_selected;
      miso_oe_out |-> !$past(ncs_in, 3);
   endproperty
   a_oe_selected: assert property (p_oe_selected)
      else $error("read data driven while deselected");
endmodule
bind laser_power_and_test_regs laser_regs_checker #(.PIX_COLS(PIX_COLS),
   .PIX_ROWS(PIX_ROWS), .PIX_AW(PIX_AW), .COLUMN_MAJOR(COLUMN_MAJOR))
   u_chk (.clk_sys_in(clk_sys_in),
   .sys_rst_in(sys_rst_in), .ncs_in(ncs_in), .miso_oe_out(miso_oe_out),
   .pixel_addr_out(pixel_addr_out), .laser_dac_code_out(laser_dac_code_out),
   .laser_range_out(laser_range_out),
   .laser_on_active_low_out(laser_on_active_low_out),
   .laser_setting_valid_out(laser_setting_valid_out));

/* File: sim/serial_master_model.sv */
// Behavioural stand-in for the controller on the four-wire port
// Assumes mode 3 framing, clock idling high, 320 ns serial period
`timescale 1ns/1ps
module serial_master_model
(
   input wire clk_sys_in,
   input wire miso_in,
   output logic ncs_out = 1'b1,
   output logic sclk_out = 1'b1,
   output logic mosi_out = 1'b0
);
   // ****************
   // One transaction
   // ****************
   task automatic xfer(input logic [15:0] sh, output logic [7:0] q);
      @(posedge clk_sys_in);
      ncs_out <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      for (int i = 15; i >= 0; i--)
      begin
         sclk_out <= 1'b0;
         mosi_out <= sh[i];
         repeat (4) @(posedge clk_sys_in);
         sclk_out <= 1'b1;
         q = {q[6:0], miso_in};
         repeat (4) @(posedge clk_sys_in);
      end
      ncs_out <= 1'b1;
      // Released line shows a changed level, not the last bit
      mosi_out <= ~mosi_out;
      repeat (8) @(posedge clk_sys_in);
   endtask
endmodule

/* File: sim/tb_laser_power_and_test_regs.sv */
// Self-checking bench for the laser and test register block
// Assumes a 2x2 column-major pixel array and the serial master model
`timescale 1ns/1ps
module tb_laser_power_and_test_regs;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic frame_tick_in = 1'b0;
   logic [1:0] power_state_in = 2'h0;
   logic [7:0] pixel_data_in = 8'h00;
   logic [7:0] pix [0:3];
   logic [7:0] q;
   wire ncs, sclk, mosi, miso;
   wire [1:0] addr, rng;
   wire [7:0] dac;
   wire nen, vld;
   int err_count = 0;
   int tests_run = 0;
   int seed = 32'h4111;
   int regs [0:127];
   int k, c;
   always #20 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) pixel_data_in <= pix[addr];
   serial_master_model u_mst (.clk_sys_in(clk_sys_in), .miso_in(miso),
      .ncs_out(ncs), .sclk_out(sclk), .mosi_out(mosi));
   laser_power_and_test_regs #(.PIX_COLS(2), .PIX_ROWS(2), .PIX_AW(2)) uut
      (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .ncs_in(ncs),
      .sclk_in(sclk), .mosi_in(mosi), .miso_out(miso), .miso_oe_out(),
      .frame_tick_in(frame_tick_in), .power_state_in(power_state_in),
      .pixel_data_in(pixel_data_in), .pixel_addr_out(addr),
      .laser_dac_code_out(dac), .laser_range_out(rng),
      .laser_on_active_low_out(nen), .laser_setting_valid_out(vld));
   // *************
   // Bench tasks
   // *************
   task automatic chk_reg(input string nm, input logic [7:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic chk_pins(input logic [11:0] e);
      tests_run++;
      if ({dac, rng, nen, vld} !== e)
      begin
         $display("wrong value laser pins expected %h seen %h", e,
            {dac, rng, nen, vld});
         err_count++;
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      regs[a] = d;
      u_mst.xfer({1'b1, a, d}, q);
   endtask
   task automatic rd(input logic [6:0] a);
      u_mst.xfer({1'b0, a, 8'h00}, q);
   endtask
   task automatic tick();
      @(posedge clk_sys_in) frame_tick_in <= 1'b1;
      @(posedge clk_sys_in) frame_tick_in <= 1'b0;
      repeat (3) @(posedge clk_sys_in);
   endtask
   function automatic logic [11:0] exp_pins();
      logic ok;
      logic [7:0] r;
      r = 8'(regs[26]);
      ok = (regs[28] ^ regs[29]) == 255 && ((regs[31] ^ r) >> 6) == 3;
      return {8'(regs[28]), r[7:6], !(ok && r[7:6] != 2'h2 && !r[0]), ok};
   endfunction
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk_sys_in);
      err_count++;
      give_verdict();
   end
   // *************
   // Main sequence
   // *************
   initial
   begin
      foreach (regs[i]) regs[i] = 0;
      foreach (pix[i]) pix[i] = 8'($random(seed));
      repeat (2) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      chk_pins(exp_pins());
      rd(7'h1F);
      chk_reg("range complement", 8'h00, q);
      rd(7'h20);
      chk_reg("unmapped", 8'h00, q);
      $display("test reset done");
      for (k = 0; k < 8; k++)
      begin
         c = $random(seed);
         if (k[0]) wr(7'h1D, 8'(~c ^ (k == 3)));
         wr(7'h1C, 8'(c));
         if (!k[0]) wr(7'h1D, 8'(~c));
         if (!k[0]) wr(7'h1F, {~2'(k), 6'h00});
         wr(7'h1A, {2'(k), 5'h00, k == 5});
         if (k[0]) wr(7'h1F, {~2'(k) ^ {1'b0, k == 7}, 6'h00});
         chk_pins(exp_pins());
         rd(7'h02);
         chk_reg("valid flag", 8'(exp_pins() & 1), 8'(q[5]));
         rd(7'h1C);
         chk_reg("current code", 8'(c), q);
      end
      $display("test laser done");
      for (k = 0; k < 4; k++)
      begin
         power_state_in <= 2'(k);
         wr(7'h2E, 8'($random(seed)));
         rd(7'h2E);
         chk_reg("observation", {2'(k), 6'h00}, q);
         tick();
         rd(7'h2E);
         chk_reg("observation", {2'(k), 6'h1F}, q);
      end
      $display("test observation done");
      wr(7'h35, 8'($random(seed)));
      rd(7'h02);
      chk_reg("pixel ready", 8'h00, 8'(q[0]));
      for (k = 0; k < 6; k++)
      begin
         tick();
         rd(7'h02);
         chk_reg("pixel flags", {6'h00, k % 4 == 0, 1'b1}, 8'(q[1:0]));
         rd(7'h35);
         // Column-major scan: address is row * 2 + column
         c = (k % 2) * 2 + (k % 4) / 2;
         chk_reg("pixel data", pix[c], q);
      end
      $display("test pixel grab done");
      give_verdict();
   end
endmodule
